// >>> sdmrd_mode_regs.v
// mode register decode and burst sequencing of a ddr sdram
`include "sdmrd_defines.vh"
module sdmrd_mode_regs #(
   parameter ADDR_W = 13,
   parameter CWL = 5,
   parameter DLL_LOCK_NCK = `SDMRD_DLL_LOCK_NCK
) (
   input wire ref_clk_i, // 10 MHz block clock
   input wire sys_rst_i, // async reset, active high
   input wire cke_i, // clock enable pin
   input wire odt_i, // termination pin
   input wire cs_n_i, // chip select, active low
   input wire ras_n_i, // row strobe, active low
   input wire cas_n_i, // column strobe, active low
   input wire we_n_i, // write enable, active low
   input wire [2:0] ba_i, // bank pins
   input wire [ADDR_W-1:0] addr_i, // address pins
   output reg [4:0] read_column_latency_o, // clocks
   output reg [4:0] total_read_latency_o, // clocks
   output wire interleave_o, // 1: interleaved order
   output wire [1:0] burst_mode_o, // burst length field
   output wire [2:0] write_recovery_o, // write recovery field
   output wire test_mode_o, // test state selected
   output wire [1:0] drive_sel_o, // {A5,A1} impedance
   output wire [2:0] rtt_nom_o, // {A9,A6,A2}
   output wire [1:0] rtt_wr_o, // write termination field
   output wire write_level_o, // write leveling on
   output wire out_disable_o, // output drivers off
   output wire term_en_o, // termination applied
   output wire term_use_wr_o, // write value applied
   output reg dll_reset_o, // one-cycle dll reset pulse
   output wire dll_locked_o, // dll lock time elapsed
   output wire dll_on_o, // dll running
   output wire pd_exit_slow_o, // slow powerdown exit
   output reg pd_exit_o, // one-cycle powerdown exit
   output reg [2:0] beat_col_o, // column of current beat
   output reg rd_beat_o, // read beat slot
   output reg wr_beat_o, // write beat captured
   output reg dq_oe_n_o, // data/strobe enable, low drives
   output reg wr_start_o // internal write start pulse
);
   localparam S_IDLE = 2'h0;
   localparam S_LAT = 2'h1;
   localparam S_BURST = 2'h2;
   localparam SYNC_W = ADDR_W + 9;

   wire [SYNC_W-1:0] pins_s;
   wire cke_s;
   wire odt_s;
   wire [3:0] cmd_s;
   wire [2:0] ba_s;
   wire [ADDR_W-1:0] a_s;
   reg [12:0] mr0_ff;
   reg [12:0] mr1_ff;
   reg [1:0] rttwr_ff;
   reg [1:0] st_ff;
   reg [1:0] nxt_st;
   reg [5:0] cnt_ff;
   reg [5:0] nxt_cnt;
   reg [2:0] beat_ff;
   reg [2:0] nxt_beat;
   reg [2:0] start_ff;
   reg [2:0] nxt_start;
   reg wr_ff;
   reg nxt_wr;
   reg chop_ff;
   reg nxt_chop;
   reg cke_q_ff;
   reg in_sr_ff;
   reg in_pd_ff;
   reg [9:0] lock_ff;
   reg [4:0] cl;
   reg [4:0] al;
   wire mrs_cmd;
   wire rd_cmd;
   wire wr_cmd;
   wire ref_cmd;
   wire [2:0] ord_col;
   wire [2:0] wr_slot;
   wire [5:0] wr_lat;

   // every pin passes two flip-flops before any decode
   sdmrd_sync #(.W(SYNC_W)) u_sync (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .d_i({cke_i, odt_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i}),
      .q_o(pins_s)
   );
   assign cke_s = pins_s[SYNC_W-1];
   assign odt_s = pins_s[SYNC_W-2];
   assign cmd_s = pins_s[SYNC_W-3:SYNC_W-6];
   assign ba_s = pins_s[ADDR_W+2:ADDR_W];
   assign a_s = pins_s[ADDR_W-1:0];

   // command decode; mode set, read and write count only while cke is held high, refresh only as cke falls
   assign mrs_cmd = cke_s & cke_q_ff & (cmd_s == 4'h0);
   assign rd_cmd = cke_s & cke_q_ff & (cmd_s == 4'h5);
   assign wr_cmd = cke_s & cke_q_ff & (cmd_s == 4'h4);
   assign ref_cmd = ~cke_s & cke_q_ff & (cmd_s == 4'h1);

   // mode registers: a mode set overwrites every field at once
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mr0_ff <= `SDMRD_MR_RESET;
         mr1_ff <= `SDMRD_MR_RESET;
         rttwr_ff <= 2'h0;
         dll_reset_o <= 1'b0;
      end else begin
         dll_reset_o <= mr0_ff[`SDMRD_MR0_DLLRST];
         if (mr0_ff[`SDMRD_MR0_DLLRST])
            mr0_ff[`SDMRD_MR0_DLLRST] <= 1'b0;
         // a fresh write in the clearing cycle wins over the clear
         if (mrs_cmd && ba_s == `SDMRD_BA_MR0)
            mr0_ff <= a_s[12:0];
         if (mrs_cmd && ba_s == `SDMRD_BA_MR1)
            mr1_ff <= a_s[12:0];
         if (mrs_cmd && ba_s == `SDMRD_BA_MR2)
            rttwr_ff <= a_s[`SDMRD_MR2_RTTWR_HI:`SDMRD_MR2_RTTWR_LO];
      end
   end

   // latency decode; no half-clock values exist in the encoding
   always @* begin
      cl = `SDMRD_CL_BASE
         + {2'h0, mr0_ff[`SDMRD_MR0_CL_HI:`SDMRD_MR0_CL_LO]};
      if (mr0_ff[`SDMRD_MR0_CL_LSB])
         cl = cl + `SDMRD_CL_HIGH;
      case (mr1_ff[`SDMRD_MR1_AL_HI:`SDMRD_MR1_AL_LO])
         `SDMRD_AL_CL1: al = cl - 5'h01;
         `SDMRD_AL_CL2: al = cl - 5'h02;
         default: al = 5'h00;
      endcase
   end

   // latency outputs registered so they are clean flip-flop values
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         read_column_latency_o <= 5'h00;
         total_read_latency_o <= 5'h00;
      end else begin
         read_column_latency_o <= cl;
         total_read_latency_o <= al + cl;
      end
   end

   assign interleave_o = mr0_ff[`SDMRD_MR0_BT];
   assign burst_mode_o = mr0_ff[`SDMRD_MR0_BL_HI:`SDMRD_MR0_BL_LO];
   assign write_recovery_o = mr0_ff[`SDMRD_MR0_WR_HI:`SDMRD_MR0_WR_LO];
   assign test_mode_o = mr0_ff[`SDMRD_MR0_TM];
   assign drive_sel_o = {mr1_ff[`SDMRD_MR1_DIC_B],
                         mr1_ff[`SDMRD_MR1_DIC_A]};
   assign rtt_nom_o = {mr1_ff[`SDMRD_MR1_RTT_C], mr1_ff[`SDMRD_MR1_RTT_B],
                       mr1_ff[`SDMRD_MR1_RTT_A]};
   assign rtt_wr_o = rttwr_ff;
   assign write_level_o = mr1_ff[`SDMRD_MR1_WLVL];
   assign out_disable_o = mr1_ff[`SDMRD_MR1_QOFF];
   assign pd_exit_slow_o = ~mr0_ff[`SDMRD_MR0_PPD];

   // write value covers writes even when the nominal value is off
   assign term_use_wr_o = odt_s & wr_ff & (st_ff == S_BURST)
                        & (rttwr_ff != 2'h0);
   assign term_en_o = odt_s & dll_on_o
                    & (term_use_wr_o | (rtt_nom_o != 3'h0));

   // self-refresh and powerdown tracking from the cke pin
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cke_q_ff <= 1'b0;
         in_sr_ff <= 1'b0;
         in_pd_ff <= 1'b0;
         pd_exit_o <= 1'b0;
      end else begin
         cke_q_ff <= cke_s;
         pd_exit_o <= in_pd_ff & cke_s;
         if (cke_s) begin
            in_sr_ff <= 1'b0;
            in_pd_ff <= 1'b0;
         end else if (cke_q_ff) begin
            in_sr_ff <= ref_cmd;
            in_pd_ff <= ~ref_cmd;
         end
      end
   end

   // dll stops in self-refresh and in slow-exit powerdown
   assign dll_on_o = ~mr1_ff[`SDMRD_MR1_DLLDIS] & ~in_sr_ff
                   & ~(in_pd_ff & ~mr0_ff[`SDMRD_MR0_PPD]);

   // lock timer restarts on every dll reset and on dll restart
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         lock_ff <= 10'h000;
      else if (dll_reset_o || !dll_on_o)
         lock_ff <= 10'h000;
      else if (lock_ff != DLL_LOCK_NCK[9:0])
         lock_ff <= lock_ff + 10'h001;
   end
   assign dll_locked_o = (lock_ff == DLL_LOCK_NCK[9:0]);

   // write latency; cwl lives in the third register, so a parameter
   assign wr_lat = {1'b0, al} + CWL[5:0];
   // fixed chop pulls the internal write two clocks ahead
   assign wr_slot = (burst_mode_o == `SDMRD_BL_FIXED4)
                  ? `SDMRD_LAST_BEAT - `SDMRD_CHOP_PULLIN
                  : `SDMRD_LAST_BEAT;

   sdmrd_beat_order u_order (
      .start_i(start_ff),
      .ilv_i(interleave_o),
      .wr_i(wr_ff),
      .chop_i(chop_ff),
      .beat_i(beat_ff),
      .col_o(ord_col)
   );

   // burst sequencer; commands during a burst are not taken
   always @* begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_beat = beat_ff;
      nxt_start = start_ff;
      nxt_wr = wr_ff;
      nxt_chop = chop_ff;
      case (st_ff)
         S_IDLE: begin
            if (rd_cmd || wr_cmd) begin
               nxt_wr = wr_cmd;
               nxt_start = a_s[2:0];
               nxt_beat = 3'h0;
               case (burst_mode_o)
                  `SDMRD_BL_FIXED4: nxt_chop = 1'b1;
                  `SDMRD_BL_OTF: nxt_chop = ~a_s[12];
                  default: nxt_chop = 1'b0;
               endcase
               if (wr_cmd)
                  nxt_cnt = wr_lat - 6'h01;
               else
                  nxt_cnt = {1'b0, al + cl} - 6'h01;
               nxt_st = S_LAT;
            end
         end
         S_LAT: begin
            if (cnt_ff == 6'h00)
               nxt_st = S_BURST;
            else
               nxt_cnt = cnt_ff - 6'h01;
         end
         S_BURST: begin
            nxt_beat = beat_ff + 3'h1;
            if (beat_ff == `SDMRD_LAST_BEAT)
               nxt_st = S_IDLE;
         end
         default: nxt_st = S_IDLE;
      endcase
   end

   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_ff <= S_IDLE;
         cnt_ff <= 6'h00;
         beat_ff <= 3'h0;
         start_ff <= 3'h0;
         wr_ff <= 1'b0;
         chop_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         beat_ff <= nxt_beat;
         start_ff <= nxt_start;
         wr_ff <= nxt_wr;
         chop_ff <= nxt_chop;
      end
   end

   // beat outputs registered one clock after the slot is chosen
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         beat_col_o <= 3'h0;
         rd_beat_o <= 1'b0;
         wr_beat_o <= 1'b0;
         dq_oe_n_o <= 1'b1;
         wr_start_o <= 1'b0;
      end else begin
         beat_col_o <= ord_col;
         rd_beat_o <= (st_ff == S_BURST) & ~wr_ff;
         // chopped writes keep the last four beats as don't-care
         wr_beat_o <= (st_ff == S_BURST) & wr_ff
                    & ~(chop_ff & beat_ff[2]);
         // chop floats the last four slots; qoff floats all of them
         dq_oe_n_o <= ~((st_ff == S_BURST) & ~wr_ff
                    & ~(chop_ff & beat_ff[2])
                    & ~out_disable_o);
         wr_start_o <= (st_ff == S_BURST) & wr_ff
                     & (beat_ff == wr_slot);
      end
   end
endmodule // sdmrd_mode_regs

// >>> sdmrd_defines.vh
// constants for the sdram mode register decode block
`ifndef SDMRD_DEFINES_VH
`define SDMRD_DEFINES_VH
// bank codes that pick the mode register on a mode set command
`define SDMRD_BA_MR0 3'h0
`define SDMRD_BA_MR1 3'h1
`define SDMRD_BA_MR2 3'h2
// mode register reset value (contents are undefined until written)
`define SDMRD_MR_RESET 13'h0000
// mode_register_zero field positions
`define SDMRD_MR0_BL_LO 0
`define SDMRD_MR0_BL_HI 1
`define SDMRD_MR0_CL_LSB 2
`define SDMRD_MR0_BT 3
`define SDMRD_MR0_CL_LO 4
`define SDMRD_MR0_CL_HI 6
`define SDMRD_MR0_TM 7
`define SDMRD_MR0_DLLRST 8
`define SDMRD_MR0_WR_LO 9
`define SDMRD_MR0_WR_HI 11
`define SDMRD_MR0_PPD 12
// mode_register_one field positions
`define SDMRD_MR1_DLLDIS 0
`define SDMRD_MR1_DIC_A 1
`define SDMRD_MR1_RTT_A 2
`define SDMRD_MR1_AL_LO 3
`define SDMRD_MR1_AL_HI 4
`define SDMRD_MR1_DIC_B 5
`define SDMRD_MR1_RTT_B 6
`define SDMRD_MR1_WLVL 7
`define SDMRD_MR1_RTT_C 9
`define SDMRD_MR1_QOFF 12
// mode_register_two write termination field
`define SDMRD_MR2_RTTWR_LO 9
`define SDMRD_MR2_RTTWR_HI 10
// burst length field codes
`define SDMRD_BL_FIXED8 2'h0
`define SDMRD_BL_OTF 2'h1
`define SDMRD_BL_FIXED4 2'h2
// additive delay field codes
`define SDMRD_AL_CL1 2'h1
`define SDMRD_AL_CL2 2'h2
// read column latency encoding
`define SDMRD_CL_BASE 5'h04
`define SDMRD_CL_HIGH 5'h08
// burst slots, last write slot, and the chop pull-in in clocks
`define SDMRD_LAST_BEAT 3'h7
`define SDMRD_CHOP_PULLIN 3'h2
// dll lock time in clock cycles
`define SDMRD_DLL_LOCK_NCK 512
`endif

// >>> sdmrd_sync.v
// two flip-flop synchroniser for a bundle of pin inputs
module sdmrd_sync #(
   parameter W = 1
) (
   input wire ref_clk_i, // block clock
   input wire sys_rst_i, // async reset, active high
   input wire [W-1:0] d_i, // pin levels
   output wire [W-1:0] q_o // synchronised levels
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   // first stage feeds only the second stage
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end
   assign q_o = sync_ff;
endmodule // sdmrd_sync

// >>> sdmrd_beat_order.v
// column index of one beat from start column, burst type and direction
module sdmrd_beat_order (
   input wire [2:0] start_i, // starting column bits [2:0]
   input wire [2:0] beat_i, // beat number in the burst
   input wire ilv_i, // 1: interleaved order
   input wire wr_i, // 1: write burst
   input wire chop_i, // 1: four-beat chop
   output reg [2:0] col_o // column index for this beat
);
   always @* begin
      if (wr_i) begin
         // writes ignore low bits; chop keeps the starting half
         if (chop_i)
            col_o = {start_i[2], beat_i[1:0]};
         else
            col_o = beat_i;
      end else if (ilv_i) begin
         col_o = start_i ^ beat_i;
      end else begin
         // low bits wrap modulo four, half flips after beat 3
         col_o = {start_i[2] ^ beat_i[2], start_i[1:0] + beat_i[1:0]};
      end
   end
endmodule // sdmrd_beat_order

// >>> sdmrd_mode_regs_props.sv
// assertion checker for the sdram mode register decode block
module sdmrd_mode_regs_props #(
   parameter ADDR_W = 13,
   parameter DLL_LOCK_NCK = 16
) (
   input wire ref_clk_i, // clock
   input wire sys_rst_i, // reset
   input wire cke_i, // clock enable
   input wire cs_n_i, // select
   input wire ras_n_i, // row strobe
   input wire cas_n_i, // column strobe
   input wire we_n_i, // write enable
   input wire [2:0] ba_i, // bank pins
   input wire [ADDR_W-1:0] addr_i, // address pins
   input wire [4:0] read_column_latency_o, // column latency
   input wire [4:0] total_read_latency_o, // total latency
   input wire interleave_o, // beat order
   input wire [1:0] burst_mode_o, // length field
   input wire [2:0] write_recovery_o, // recovery field
   input wire [1:0] drive_sel_o, // impedance
   input wire [2:0] rtt_nom_o, // termination
   input wire out_disable_o, // drivers off
   input wire dll_reset_o, // dll reset pulse
   input wire dll_locked_o, // lock done
   input wire pd_exit_slow_o, // slow exit
   input wire [2:0] beat_col_o, // beat column
   input wire rd_beat_o, // read slot
   input wire wr_beat_o, // write beat
   input wire dq_oe_n_o, // drivers, low on
   input wire wr_start_o // internal write
);
   reg [3:0] cnt0_ff, cnt1_ff;
   reg [ADDR_W-1:0] m0_ff, m1_ff;
   reg [5:0] lk_ff;
   wire mode_set_command = cke_i & ~(cs_n_i | ras_n_i | cas_n_i | we_n_i);
   wire [4:0] cl_exp = 5'h04 + {2'h0, m0_ff[6:4]} + {1'h0, m0_ff[2], 3'h0};
   // pin-side copy of registers zero and one; compared only once the sync has settled
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt0_ff <= 4'h0;
         cnt1_ff <= 4'h0;
         m0_ff <= {ADDR_W{1'b0}};
         m1_ff <= {ADDR_W{1'b0}};
         lk_ff <= 6'h00;
      end else begin
         cnt0_ff <= (mode_set_command && ba_i == 3'h0) ? 4'h0 :
            cnt0_ff + {3'h0, cnt0_ff != 4'hf};
         cnt1_ff <= (mode_set_command && ba_i == 3'h1) ? 4'h0 :
            cnt1_ff + {3'h0, cnt1_ff != 4'hf};
         if (mode_set_command && ba_i == 3'h0) m0_ff <= addr_i;
         if (mode_set_command && ba_i == 3'h1) m1_ff <= addr_i;
         lk_ff <= dll_reset_o ? 6'h00 : lk_ff + {5'h00, lk_ff != 6'h3f};
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence drive4; !dq_oe_n_o [*4]; endsequence
   sequence float4; dq_oe_n_o [*4]; endsequence
   sequence eight_slots; rd_beat_o [*8] ##1 !rd_beat_o; endsequence
   a_mr0_fields: assert property (
      cnt0_ff == 4'h8 |-> interleave_o == m0_ff[3] &&
      burst_mode_o == m0_ff[1:0] && write_recovery_o == m0_ff[11:9] &&
      pd_exit_slow_o == !m0_ff[12]) else $error("mode zero fields wrong");
   a_read_latency: assert property (
      cnt0_ff == 4'h8 |-> read_column_latency_o == cl_exp)
      else $error("column latency wrong");
   a_total_latency: assert property (
      cnt0_ff >= 4'h8 && cnt1_ff >= 4'h8 |-> total_read_latency_o ==
      read_column_latency_o + ((m1_ff[4:3] == 2'h0) ? 5'h00 :
      read_column_latency_o - {3'h0, m1_ff[4:3]}))
      else $error("total latency wrong");
   a_mr1_fields: assert property (
      cnt1_ff == 4'h8 |-> drive_sel_o == {m1_ff[5], m1_ff[1]} &&
      rtt_nom_o == {m1_ff[9], m1_ff[6], m1_ff[2]} &&
      out_disable_o == m1_ff[12]) else $error("mode one fields wrong");
   a_dll_selfclear: assert property (
      dll_reset_o |=> !dll_reset_o) else $error("dll reset not cleared");
   a_lock_wait: assert property (
      $rose(dll_locked_o) |-> lk_ff >= DLL_LOCK_NCK - 1)
      else $error("lock reported early");
   a_qoff_float: assert property (
      out_disable_o |-> dq_oe_n_o) else $error("drivers on while disabled");
   a_read_slots: assert property (
      $rose(rd_beat_o) |-> eight_slots) else $error("read slot count wrong");
   a_chop_float: assert property (
      $rose(rd_beat_o) && burst_mode_o == 2'h2 && !out_disable_o |->
      drive4 ##1 float4) else $error("chopped read drive wrong");
   a_write_pullin: assert property (
      wr_start_o && burst_mode_o == 2'h2 |->
      $past(wr_beat_o, 2) && !$past(wr_beat_o))
      else $error("chopped write start not pulled in");
endmodule // sdmrd_mode_regs_props

bind sdmrd_mode_regs sdmrd_mode_regs_props #(
   .ADDR_W(ADDR_W),
   .DLL_LOCK_NCK(DLL_LOCK_NCK)
) u_props (
   .ref_clk_i, .sys_rst_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i,
   .ba_i, .addr_i, .read_column_latency_o, .total_read_latency_o,
   .interleave_o, .burst_mode_o, .write_recovery_o, .drive_sel_o,
   .rtt_nom_o, .out_disable_o, .dll_reset_o, .dll_locked_o,
   .pd_exit_slow_o, .beat_col_o, .rd_beat_o, .wr_beat_o, .dq_oe_n_o,
   .wr_start_o
);

// >>> sdmrd_ctrl_model.sv
// memory controller model driving the command pins
module sdmrd_ctrl_model (
   input wire ref_clk_i, // block clock
   output reg cke_o, // clock enable
   output reg odt_o, // termination pin
   output reg cs_n_o, // select
   output reg ras_n_o, // row strobe
   output reg cas_n_o, // column strobe
   output reg we_n_o, // write enable
   output reg [2:0] ba_o, // bank pins
   output reg [12:0] addr_o // address pins
);
   initial begin
      cke_o = 1'b0;
      odt_o = 1'b0;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
      ba_o = 3'h0;
      addr_o = 13'h0000;
   end
   // one command for one clock; deselected lines then carry junk
   task issue(input [3:0] c, input [2:0] b, input [12:0] a, input k);
      @(posedge ref_clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
      ba_o <= b;
      addr_o <= a;
      cke_o <= k;
      @(posedge ref_clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
      ba_o <= ~b;
      addr_o <= ~a;
   endtask
   // reserved bits cleared, test state and dll disable never asked for
   task mode_set(input [2:0] b, input [12:0] a);
      issue(4'h0, b, a & (b == 3'h0 ? 13'h1f7f :
         b == 3'h1 ? 13'h12fe : 13'h0600), 1'b1);
      repeat (10) @(posedge ref_clk_i);
   endtask
   task pin_odt(input v);
      @(posedge ref_clk_i);
      odt_o <= v;
   endtask
endmodule // sdmrd_ctrl_model

// >>> tb_sdram_mode_register_decode.sv
// self-checking bench for the sdram mode register decode block
module tb_sdram_mode_register_decode;
   timeunit 1ns;
   timeprecision 1ns;
   reg ref_clk = 1'b0;
   reg sys_rst = 1'b1;
   wire cke, odt, cs_n, ras_n, cas_n, we_n;
   wire [2:0] ba, wrc, rtt, col;
   wire [12:0] addr;
   wire [4:0] cl, rl;
   wire [1:0] bm, drv, rttwr;
   wire ilv, qoff, ten, tuse, lock, dll_on, pslow, rd, wr, oe_n;
   wire tm, wl;
   int num_errors = 0;
   int num_checks = 0;
   int i, k, ce;
   logic [5:0] exp_q[$];
   logic [5:0] e;
   logic seen_wr_term = 1'b0;
   logic [12:0] m0, m1;
   logic [2:0] s;

   always #50 ref_clk = ~ref_clk;

   sdmrd_ctrl_model u_ctrl (.ref_clk_i(ref_clk), .cke_o(cke), .odt_o(odt),
      .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
      .ba_o(ba), .addr_o(addr));

   sdmrd_mode_regs #(.DLL_LOCK_NCK(16)) u_dut (.ref_clk_i(ref_clk),
      .sys_rst_i(sys_rst), .cke_i(cke), .odt_i(odt), .cs_n_i(cs_n),
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba),
      .addr_i(addr), .read_column_latency_o(cl), .total_read_latency_o(rl),
      .interleave_o(ilv), .burst_mode_o(bm), .write_recovery_o(wrc),
      .test_mode_o(tm), .drive_sel_o(drv), .rtt_nom_o(rtt), .rtt_wr_o(rttwr),
      .write_level_o(wl), .out_disable_o(qoff), .term_en_o(ten),
      .term_use_wr_o(tuse), .dll_reset_o(), .dll_locked_o(lock),
      .dll_on_o(dll_on), .pd_exit_slow_o(pslow), .pd_exit_o(),
      .beat_col_o(col), .rd_beat_o(rd), .wr_beat_o(wr), .dq_oe_n_o(oe_n),
      .wr_start_o());

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wrap_up;
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // note each slot of one burst, only the first four of a chopped write: {read, column valid, drivers off, column}
   task automatic note(input logic rq, input logic ch, input logic il,
         input logic off);
      logic [2:0] b, c;
      for (int j = 0; j < 8; j++) begin
         b = j[2:0];
         if (!rq)
            c = ch ? {s[2], b[1:0]} : b;
         else if (il)
            c = s ^ b;
         else
            c = {s[2] ^ b[2], s[1:0] + b[1:0]};
         if (rq || !ch || j < 4)
            exp_q.push_back({rq, !(ch && j >= 4), off | (ch && j >= 4), c});
      end
   endtask

   // one read or write from a random start column, then wait for its beats
   task automatic burst(input logic [3:0] cmd, input logic bc,
         input logic off);
      logic ch;
      ch = (m0[1:0] == 2'h2) || (m0[1:0] == 2'h1 && !bc);
      s = 3'($urandom_range(7));
      note(cmd == 4'h5, ch, m0[3], off);
      u_ctrl.issue(cmd, 3'h0, {bc, 9'h000, s}, 1'b1);
      for (k = 0; k < 80 && exp_q.size() != 0; k++) @(posedge ref_clk);
      if (exp_q.size() != 0) begin
         num_errors++;
         wrap_up;
      end
      repeat (4) @(posedge ref_clk);
   endtask

   // beats are checked against the oldest note when they appear
   always @(negedge ref_clk) begin
      seen_wr_term = seen_wr_term | (tuse & ten);
      if (rd | wr) begin
         if (exp_q.size() == 0) begin
            check(16'h0001, 16'h0000);
         end else begin
            e = exp_q.pop_front();
            check(rd, e[5]);
            if (e[4]) check(col, e[2:0]);
            if (e[5]) check(oe_n, e[3]);
         end
      end
   end

   initial begin
      void'($urandom(52));
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      u_ctrl.issue(4'hf, 3'h0, 13'h0000, 1'b1);
      repeat (4) @(posedge ref_clk);
      // every register written before use, dll reset last
      u_ctrl.mode_set(3'h2, 13'h0200);
      u_ctrl.mode_set(3'h1, 13'h0000);
      u_ctrl.mode_set(3'h0, 13'h0100);
      for (k = 0; k < 100 && lock !== 1'b1; k++) @(posedge ref_clk);
      check(lock, 1'b1);
      if (lock !== 1'b1) wrap_up;
      check(rttwr, 2'h1);
      // random whole-register writes; old contents must not survive
      for (i = 0; i < 8; i++) begin
         m0 = 13'($urandom) & 13'h1e7f;
         m1 = 13'($urandom) & 13'h107e;
         m0[1:0] = 2'($urandom_range(2));
         m1[4:3] = 2'($urandom_range(2));
         // total latency is five bits: no high column step with additive delay
         if (m1[4:3] != 2'h0) m0[2] = 1'b0;
         // write leveling only with outputs off, so any termination is legal
         m1[7] = m1[12];
         u_ctrl.mode_set(3'h0, m0);
         u_ctrl.mode_set(3'h1, m1);
         ce = 4 + m0[6:4] + 8 * m0[2];
         check(cl, ce[15:0]);
         check(rl, 16'(ce + (m1[4:3] == 2'h0 ? 0 : ce - m1[4:3])));
         check({ilv, bm}, {m0[3], m0[1:0]});
         check({wrc, pslow}, {m0[11:9], !m0[12]});
         check(drv, {m1[5], m1[1]});
         check({rtt, qoff}, {1'b0, m1[6], m1[2], m1[12]});
         check({tm, wl}, {m0[7], m1[7]});
      end
      // every length mode, both orders, both per-command chop levels
      u_ctrl.mode_set(3'h1, 13'h0000);
      u_ctrl.pin_odt(1'b1);
      for (i = 0; i < 12; i++) begin
         m0 = {1'b1, 3'h1, 2'h0, 3'h1, i[0], 1'b0, 2'(i / 4)};
         u_ctrl.mode_set(3'h0, m0);
         burst(4'h5, i[1], 1'b0);
         burst(4'h4, i[1], 1'b0);
      end
      check(seen_wr_term, 1'b1);
      u_ctrl.mode_set(3'h1, 13'h1000);
      burst(4'h5, 1'b1, 1'b1);
      // self-refresh stops the dll and its exit restarts it
      u_ctrl.mode_set(3'h1, 13'h0000);
      u_ctrl.pin_odt(1'b0);
      u_ctrl.issue(4'h1, 3'h0, 13'h0000, 1'b0);
      repeat (6) @(posedge ref_clk);
      check(dll_on, 1'b0);
      u_ctrl.issue(4'hf, 3'h0, 13'h0000, 1'b1);
      repeat (6) @(posedge ref_clk);
      check(dll_on, 1'b1);
      wrap_up;
   end
endmodule // tb_sdram_mode_register_decode
